// *** rtl/byte_fifo_pkg.sv ***
// Shared constants and carrier types for one byte FIFO channel
package byte_fifo_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int DATA_WIDTH    = 8;
	localparam int DEFAULT_DEPTH = 256;
	localparam int STAGE_DEPTH   = 8;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] OUT_RESET_VALUE = 8'h00;
	localparam logic       FULL_N_RESET    = 1'b1;
	localparam logic       EMPTY_N_RESET   = 1'b0;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic fullN;
		logic emptyN;
	} flags_t;

	typedef struct packed {
		logic                  valid;
		logic [DATA_WIDTH-1:0] data;
	} byte_req_t;

endpackage

// *** rtl/dual_clock_byte_fifo.sv ***
// One byte FIFO channel with write-clock and read-clock inputs sampled on clk
// Contract
// - Clear resets channel regardless of either clock
// - Clear returns both pointers to first location
// - Clear drives full flag high, empty low
// - Clear loads output register with zeros
// - Write edge with enable, not full, stores byte
// - Write enable high: nothing stored
// - Full flag low; writes ignored while full
// - Read from full channel releases full flag
// - Full flag changes only on write edges
// - Read edge with enable, not empty, outputs oldest
// - Read enable high: output and pointer hold
// - Empty flag low when pointers equal
// - Write into empty raises empty on read edge
// - Read enable ignored while empty
// - Output enable low drives bus, else released
// - Depth parameter; full after exactly depth writes
// - Works with asynchronous or identical clocks
// - Eight-bit input and output data ports
// - Full release may slip one write edge
// - Empty release may slip two read edges
// - First byte flagged readable on third read edge after commit
// - Second channel is an independent copy
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Staging FIFO
// ----------------------------------------
module byte_stage_fifo #(
	parameter int WIDTH = byte_fifo_pkg::DATA_WIDTH,
	parameter int DEPTH = byte_fifo_pkg::STAGE_DEPTH
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rstN,
	// Fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    head_r;
	logic [AW-1:0]    tail_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	assign inReady  = (count_r != (AW+1)'(DEPTH));
	assign outValid = (count_r != '0);
	assign outData  = store[head_r];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_ff @(posedge clk) begin
		if (push) begin
			store[tail_r] <= inData;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			head_r  <= '0;
			tail_r  <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				tail_r <= tail_r + AW'(1);
			end
			if (pop) begin
				head_r <= head_r + AW'(1);
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ----------------------------------------
// Channel
// ----------------------------------------
// Nothing here is shared, so a second channel is simply a second instance
module dual_clock_byte_fifo #(
	parameter int DEPTH = byte_fifo_pkg::DEFAULT_DEPTH
) (
	// System
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clear_n,
	// Write side
	input  wire logic       write_side_clock,
	input  wire logic       write_accept_n,
	input  wire logic [7:0] write_byte_in,
	output logic            full_flag_n,
	// Read side
	input  wire logic       read_side_clock,
	input  wire logic       read_accept_n,
	input  wire logic       drive_output_n,
	output logic      [7:0] read_byte_out,
	output logic            read_byte_oe,
	output logic            empty_flag_n
);
	localparam int AW = $clog2(DEPTH);
	localparam int DW = byte_fifo_pkg::DATA_WIDTH;

	function automatic logic [AW:0] toGray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [AW:0] fromGray(input logic [AW:0] g);
		logic [AW:0] b;
		b[AW] = g[AW];
		for (int i = AW - 1; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// ----------------------------------------
	// Reset and clock edges
	// ----------------------------------------
	// Clear acts without any clock, merged into the async reset
	logic rstN;
	assign rstN = reset_n && clear_n;

	logic wClkPrev_r;
	logic rClkPrev_r;
	logic wEdge;
	logic rEdge;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wClkPrev_r <= 1'b0;
			rClkPrev_r <= 1'b0;
		end else begin
			wClkPrev_r <= write_side_clock;
			rClkPrev_r <= read_side_clock;
		end
	end

	// Clocks keep being watched during clear, so free-running is harmless
	assign wEdge = write_side_clock && !wClkPrev_r;
	assign rEdge = read_side_clock && !rClkPrev_r;

	// ----------------------------------------
	// Write side
	// ----------------------------------------
	logic                  stageReady;
	logic                  stageValid;
	logic [DW-1:0]         stageData;
	logic                  wTake;
	logic [AW:0]           wBin_r;
	logic [AW:0]           wBinNxt;
	logic [AW:0]           rGraySyncW1_r;
	logic [AW:0]           rGraySyncW2_r;
	logic [AW:0]           rBinAtW;
	logic                  fullN_r;
	logic                  emptyN_r;
	logic                  rTake;
	logic [AW:0]           rBin_r;
	byte_fifo_pkg::flags_t flags;
	byte_fifo_pkg::byte_req_t wReq;

	assign wReq.valid = wEdge && !write_accept_n;
	assign wReq.data  = write_byte_in;
	assign flags      = '{fullN: fullN_r, emptyN: emptyN_r};
	// Full and enable high both block the capture
	assign wTake   = wReq.valid && flags.fullN && stageReady;
	assign wBinNxt = wBin_r + (AW+1)'(wTake);
	assign rBinAtW = fromGray(rGraySyncW2_r);

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			wBin_r        <= '0;
			rGraySyncW1_r <= '0;
			rGraySyncW2_r <= '0;
		end else if (wEdge) begin
			wBin_r        <= wBinNxt;
			rGraySyncW1_r <= toGray(rBin_r);
			rGraySyncW2_r <= rGraySyncW1_r;
		end
	end

	// Full only re-evaluated on write edges; a late read waits one edge
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			fullN_r <= byte_fifo_pkg::FULL_N_RESET;
		end else if (wEdge) begin
			// Judged against the value the sync stage takes now, so the flag
			// always agrees with the pointers it stands beside
			fullN_r <= ((wBinNxt - fromGray(rGraySyncW1_r)) != (AW+1)'(DEPTH));
		end
	end

	// ----------------------------------------
	// Staging and array commit
	// ----------------------------------------
	logic [DW-1:0] mem [DEPTH];
	logic [AW:0]   cBin_r;
	logic          commit;

	// Commit yields to a read in the same cycle, one access per cycle
	byte_stage_fifo #(
		.WIDTH (DW),
		.DEPTH (byte_fifo_pkg::STAGE_DEPTH)
	) u_stage (
		.clk      (clk),
		.rstN     (rstN),
		.inValid  (wTake),
		.inReady  (stageReady),
		.inData   (wReq.data),
		.outValid (stageValid),
		.outReady (!rTake),
		.outData  (stageData)
	);

	assign commit = stageValid && !rTake;

	always_ff @(posedge clk) begin
		if (commit) begin
			mem[cBin_r[AW-1:0]] <= stageData;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cBin_r <= '0;
		end else if (commit) begin
			cBin_r <= cBin_r + (AW+1)'(1);
		end
	end

	// ----------------------------------------
	// Read side
	// ----------------------------------------
	logic [AW:0]   rBinNxt;
	logic [AW:0]   cGraySyncR1_r;
	logic [AW:0]   cGraySyncR2_r;
	logic [AW:0]   cBinAtR;
	logic [DW-1:0] outByte_r;

	assign rTake   = rEdge && !read_accept_n && flags.emptyN;
	assign rBinNxt = rBin_r + (AW+1)'(rTake);
	assign cBinAtR = fromGray(cGraySyncR2_r);

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			rBin_r        <= '0;
			cGraySyncR1_r <= '0;
			cGraySyncR2_r <= '0;
		end else if (rEdge) begin
			rBin_r        <= rBinNxt;
			cGraySyncR1_r <= toGray(cBin_r);
			cGraySyncR2_r <= cGraySyncR1_r;
		end
	end

	// Two sync stages plus the flag register put first-byte latency at three read edges
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			emptyN_r <= byte_fifo_pkg::EMPTY_N_RESET;
		end else if (rEdge) begin
			emptyN_r <= (rBinNxt != cBinAtR);
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			outByte_r <= byte_fifo_pkg::OUT_RESET_VALUE;
		end else if (rTake) begin
			outByte_r <= mem[rBin_r[AW-1:0]];
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign full_flag_n   = flags.fullN;
	assign empty_flag_n  = flags.emptyN;
	assign read_byte_out = outByte_r;
	assign read_byte_oe  = !drive_output_n;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_CLEAR_PTRS: assert property (@(posedge clk) disable iff (!reset_n)
		!clear_n |-> (wBin_r == '0) && (rBin_r == '0))
		else $error("Pointers not at first location during clear");

	AST_CLEAR_FLAGS: assert property (@(posedge clk) disable iff (!reset_n)
		!clear_n |-> full_flag_n && !empty_flag_n)
		else $error("Flags wrong during clear");

	AST_CLEAR_OUT: assert property (@(posedge clk) disable iff (!reset_n)
		!clear_n |-> (read_byte_out == 8'h00))
		else $error("Output register not zero during clear");

	AST_WRITE_HOLD: assert property (@(posedge clk) disable iff (!rstN)
		(wEdge && write_accept_n) |=> $stable(wBin_r))
		else $error("Write pointer moved with write enable high");

	AST_NO_WRITE_FULL: assert property (@(posedge clk) disable iff (!rstN)
		(wEdge && !full_flag_n) |=> (wBin_r == $past(wBin_r)))
		else $error("Write taken while full");

	AST_READ_HOLD: assert property (@(posedge clk) disable iff (!rstN)
		(rEdge && (read_accept_n || !empty_flag_n)) |=> $stable(rBin_r) && $stable(read_byte_out))
		else $error("Read side moved without a valid read");

	AST_FULL_ON_WEDGE: assert property (@(posedge clk) disable iff (!rstN)
		$changed(full_flag_n) |-> $past(wEdge))
		else $error("Full flag changed off a write edge");

	AST_EMPTY_ON_REDGE: assert property (@(posedge clk) disable iff (!rstN)
		$changed(empty_flag_n) |-> $past(rEdge))
		else $error("Empty flag changed off a read edge");

	AST_FULL_COUNT: assert property (@(posedge clk) disable iff (!rstN)
		!full_flag_n |-> ((wBin_r - rBinAtW) == (AW+1)'(DEPTH)))
		else $error("Full flag low without depth bytes held");

	AST_EMPTY_EQ: assert property (@(posedge clk) disable iff (!rstN)
		(rEdge && (rBinNxt == cBinAtR)) |=> !empty_flag_n)
		else $error("Empty flag high with equal pointers");

	AST_OCCUPANCY: assert property (@(posedge clk) disable iff (!rstN)
		(wBin_r - rBin_r) <= (AW+1)'(DEPTH))
		else $error("More bytes held than the depth");

	AST_COMMIT_BETWEEN: assert property (@(posedge clk) disable iff (!rstN)
		(cBin_r - rBin_r) <= (wBin_r - rBin_r))
		else $error("Commit pointer outside read and write pointers");
endmodule

`default_nettype wire

// *** testbench/fifo_clock_model.sv ***
// Far-side writer and reader clocks for one byte FIFO channel
`timescale 1ns/1ps
`default_nettype none
module fifo_clock_model (
	// System
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic sameClock,
	// Far-side clocks
	output logic      wrClk,
	output logic      rdClk,
	output logic      wrTick,
	output logic      rdTick
);
	logic [1:0] wrCnt_r;
	logic [2:0] rdCnt_r;
	logic       wrPrev_r;
	logic       rdPrev_r;

	// ----------------------------------------
	// Free-running clocks
	// ----------------------------------------
	// Clear never stops them, only reset does
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wrCnt_r <= 2'h0;
			rdCnt_r <= 3'h0;
		end else begin
			wrCnt_r <= wrCnt_r + 2'h1;
			rdCnt_r <= (rdCnt_r == 3'h5) ? 3'h0 : rdCnt_r + 3'h1;
		end
	end

	// Without sameClock, periods of four and six cycles keep the two phases drifting
	assign wrClk = wrCnt_r[1];
	assign rdClk = sameClock ? wrClk : (rdCnt_r > 3'h2);

	always_ff @(posedge clk) begin
		wrPrev_r <= wrClk;
		rdPrev_r <= rdClk;
	end

	// High in the cycle whose closing edge takes a transfer
	assign wrTick = wrClk & ~wrPrev_r;
	assign rdTick = rdClk & ~rdPrev_r;
endmodule
`default_nettype wire

// *** testbench/dual_clock_byte_fifo_tb.sv ***
// Self-checking bench for one byte FIFO channel
`timescale 1ns/1ps
`default_nettype none
module dual_clock_byte_fifo_tb;
	logic       clk;
	logic       reset_n;
	logic       clear_n;
	logic       sameClock;
	logic       wrClk;
	logic       rdClk;
	logic       wrTick;
	logic       rdTick;
	logic       write_accept_n;
	logic [7:0] write_byte_in;
	logic       full_flag_n;
	logic       read_accept_n;
	logic       drive_output_n;
	logic [7:0] read_byte_out;
	logic       read_byte_oe;
	logic       empty_flag_n;
	int         fails = 0;
	int         comparisons = 0;

	fifo_clock_model model (.clk(clk), .reset_n(reset_n), .sameClock(sameClock),
		.wrClk(wrClk), .rdClk(rdClk), .wrTick(wrTick), .rdTick(rdTick));

	dual_clock_byte_fifo #(.DEPTH(256)) DUT (.clk(clk), .reset_n(reset_n),
		.clear_n(clear_n), .write_side_clock(wrClk), .write_accept_n(write_accept_n),
		.write_byte_in(write_byte_in), .full_flag_n(full_flag_n),
		.read_side_clock(rdClk), .read_accept_n(read_accept_n),
		.drive_output_n(drive_output_n), .read_byte_out(read_byte_out),
		.read_byte_oe(read_byte_oe), .empty_flag_n(empty_flag_n));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (fails == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Bounded wait for a tick or for a flag to go high (flag), on the read side if rd
	task automatic waitFor(input logic rd, input logic flag);
		int n;
		n = 0;
		@(negedge clk);
		while ((flag ? (rd ? empty_flag_n : full_flag_n) : (rd ? rdTick : wrTick)) !== 1'b1) begin
			n++;
			if (n > 100) begin
				fails++;
				report_and_stop();
			end
			@(negedge clk);
		end
		if (!flag) begin
			@(posedge clk);
		end
	endtask

	// Data is inverted once taken so a stale value never looks valid
	task automatic writeByte(input logic en, input logic [7:0] d);
		@(posedge clk);
		write_accept_n <= !en;
		write_byte_in <= d;
		waitFor(1'b0, 1'b0);
		write_accept_n <= 1'b1;
		write_byte_in <= ~d;
	endtask

	task automatic readByte(input logic en);
		@(posedge clk);
		read_accept_n <= !en;
		waitFor(1'b1, 1'b0);
		read_accept_n <= 1'b1;
		@(negedge clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic resetScenario();
		check({7'h00, full_flag_n}, 8'h01);
		check({7'h00, empty_flag_n}, 8'h00);
		check(read_byte_out, 8'h00);
		check({7'h00, read_byte_oe}, 8'h01);
		@(posedge clk) drive_output_n <= 1'b1;
		@(negedge clk) check({7'h00, read_byte_oe}, 8'h00);
		@(posedge clk) drive_output_n <= 1'b0;
		@(negedge clk) check({7'h00, read_byte_oe}, 8'h01);
		readByte(1'b1);
		check(read_byte_out, 8'h00);
	endtask

	task automatic orderScenario();
		writeByte(1'b1, 8'h11);
		writeByte(1'b0, 8'hEE);
		writeByte(1'b1, 8'h22);
		writeByte(1'b1, 8'h33);
		waitFor(1'b1, 1'b1);
		readByte(1'b1);
		check(read_byte_out, 8'h11);
		readByte(1'b0);
		check(read_byte_out, 8'h11);
		readByte(1'b1);
		check(read_byte_out, 8'h22);
		readByte(1'b1);
		check(read_byte_out, 8'h33);
		readByte(1'b1);
		check(read_byte_out, 8'h33);
		check({7'h00, empty_flag_n}, 8'h00);
	endtask

	task automatic fillScenario();
		for (int i = 0; i < 256; i++) begin
			if (i == 255) begin
				@(negedge clk);
				check({7'h00, full_flag_n}, 8'h01);
			end
			writeByte(1'b1, 8'(i) ^ 8'hA5);
		end
		@(negedge clk) check({7'h00, full_flag_n}, 8'h00);
		writeByte(1'b1, 8'h5B);
		@(negedge clk);
		check({7'h00, full_flag_n}, 8'h00);
		readByte(1'b1);
		check(read_byte_out, 8'hA5);
		waitFor(1'b0, 1'b1);
		for (int i = 1; i < 256; i++) begin
			readByte(1'b1);
			check(read_byte_out, 8'(i) ^ 8'hA5);
		end
	endtask

	task automatic clearScenario();
		writeByte(1'b1, 8'h77);
		@(posedge clk) clear_n <= 1'b0;
		repeat (3) @(posedge clk);
		check({7'h00, full_flag_n}, 8'h01);
		check({7'h00, empty_flag_n}, 8'h00);
		check(read_byte_out, 8'h00);
		clear_n <= 1'b1;
		writeByte(1'b1, 8'hC3);
		waitFor(1'b1, 1'b1);
		readByte(1'b1);
		check(read_byte_out, 8'hC3);
	endtask

	task automatic sameClockScenario();
		@(posedge clk) sameClock <= 1'b1;
		writeByte(1'b1, 8'h3C);
		waitFor(1'b1, 1'b1);
		readByte(1'b1);
		check(read_byte_out, 8'h3C);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		reset_n = 1'b0;
		clear_n = 1'b1;
		sameClock = 1'b0;
		write_accept_n = 1'b1;
		write_byte_in = 8'h00;
		read_accept_n = 1'b1;
		drive_output_n = 1'b0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		resetScenario();
		orderScenario();
		fillScenario();
		clearScenario();
		sameClockScenario();
		report_and_stop();
	end
endmodule
`default_nettype wire
